// ### hdl/pspwm_top.sv
// Power stage PWM configuration, compare and event logic with an APB slave
`timescale 1ns/100ps
`include "pspwm_map.svh"
module pspwm_top (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic fast_clock,
    input wire logic slow_clock,
    input wire logic slave_autorun,
    input wire logic stage_input_main,
    input wire logic stage_input_alt_a,
    input wire logic stage_input_alt_b,
    input wire logic comparator_out,
    input wire logic sync_error,
    input wire logic port_out_a,
    input wire logic port_out_b,
    output pspwm_pkg::pspwm_pins_type pins,
    output logic irq
);
    import pspwm_pkg::*;
    logic rst_meta, rst_n;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // APB slave, zero wait states
    logic wr_en, rd_en;
    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;

    pspwm_shadow_type staged, live;
    pspwm_cfg_type cfg;
    pspwm_ctl_type ctl;
    logic [7:0] temp_hi;
    logic [1:0] input_lo_sel;
    logic [2:0] irq_mask, irq_flag;
    logic rb_written_last, pending;
    logic hit_known;
    assign hit_known = paddr inside {`PSPWM_OFF_SYNC_OUT, `PSPWM_OFF_SET_A, `PSPWM_OFF_RESET_A, `PSPWM_OFF_SET_B,
        `PSPWM_OFF_RESET_B, `PSPWM_OFF_GEN_CFG, `PSPWM_OFF_GEN_CTL, `PSPWM_OFF_INPUT_CTL,
        `PSPWM_OFF_IRQ_MASK, `PSPWM_OFF_IRQ_FLAG, `PSPWM_OFF_STATUS};
    assign pslverr = psel && penable && !hit_known;

    // Wide writes: bits 15:8 write the latch, bits 7:0 commit latch plus low byte
    logic [15:0] wide_val;
    assign wide_val = {temp_hi, pwdata[7:0]};
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            temp_hi <= `PSPWM_RST_BYTE;
        end else if (wr_en && pwdata[16]) begin
            temp_hi <= pwdata[15:8];
        end
    end

    logic is_wide, lo_commit;
    assign is_wide = paddr == `PSPWM_OFF_SET_A || paddr == `PSPWM_OFF_RESET_A ||
                     paddr == `PSPWM_OFF_SET_B || paddr == `PSPWM_OFF_RESET_B;
    assign lo_commit = wr_en && is_wide && !pwdata[16];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            staged <= '0;
        end else if (lo_commit || (wr_en && paddr == `PSPWM_OFF_SYNC_OUT)) begin
            case (paddr)
                `PSPWM_OFF_SET_A: staged.set_a <= wide_val[11:0];
                `PSPWM_OFF_RESET_A: staged.reset_a <= wide_val[11:0];
                `PSPWM_OFF_SET_B: staged.set_b <= wide_val[11:0];
                `PSPWM_OFF_RESET_B: begin
                    staged.reset_b <= wide_val;
                    if (cfg.half_duty_mode) begin
                        staged.reset_a <= wide_val[11:0];
                        staged.set_a <= staged.set_b;
                    end
                end
                `PSPWM_OFF_SYNC_OUT: staged.sync_out <= pwdata[7:0];
                default: staged.set_a <= staged.set_a;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg <= `PSPWM_RST_BYTE;
            ctl <= `PSPWM_RST_BYTE;
            input_lo_sel <= 2'h0;
            irq_mask <= 3'h0;
        end else if (wr_en) begin
            case (paddr)
                `PSPWM_OFF_GEN_CFG: cfg <= pwdata[7:0];
                `PSPWM_OFF_GEN_CTL: ctl <= pwdata[7:0];
                `PSPWM_OFF_INPUT_CTL: input_lo_sel <= pwdata[1:0];
                `PSPWM_OFF_IRQ_MASK: irq_mask <= pwdata[2:0];
                default: ctl <= ctl;
            endcase
        end
    end

    // Prescaler on the chosen counter clock (both enables sync to clk)
    logic tick_src, tick;
    logic [7:0] pre_cnt, pre_lim;
    assign tick_src = cfg.clock_source_select ? fast_clock : slow_clock;
    always_comb begin
        case (ctl.prescale_select)
            2'h0: pre_lim = 8'h00;
            2'h1: pre_lim = `PSPWM_DIV_4;
            2'h2: pre_lim = `PSPWM_DIV_32;
            default: pre_lim = `PSPWM_DIV_256;
        endcase
    end
    assign tick = tick_src && pre_cnt >= pre_lim;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_cnt <= 8'h00;
        end else if (tick_src) begin
            pre_cnt <= (pre_cnt >= pre_lim) ? 8'h00 : pre_cnt + 8'h01;
        end
    end

    // Run control
    pspwm_state_type state;
    logic [11:0] counter;
    logic [3:0] enh_cycle;
    logic cycle_end, running;
    assign running = state != PSPWM_IDLE;
    // Flank width: fm_tgt bits are SA, RA, SB, RB; one extra count in the first N of 16 cycles
    logic fm_add;
    logic [3:0] fm_tgt;
    assign fm_add = enh_cycle < live.reset_b[15:12];
    always_comb begin
        case ({ctl.flank_mod_select_hi, ctl.flank_mod_select_lo})
            2'h0: fm_tgt = 4'h8;
            2'h1: fm_tgt = 4'ha;
            2'h2: fm_tgt = 4'h4;
            default: fm_tgt = 4'h5;
        endcase
    end
    assign cycle_end = tick && running && counter == live.reset_b[11:0] + {11'h000, fm_add && fm_tgt[3]};
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= PSPWM_IDLE;
        end else begin
            case (state)
                PSPWM_IDLE: if (ctl.run_control || slave_autorun) state <= PSPWM_RUN;
                PSPWM_RUN: begin
                    if (!ctl.run_control && !slave_autorun) begin
                        state <= (ctl.complete_cycle_halt) ? PSPWM_FINISH : PSPWM_IDLE;
                    end
                end
                PSPWM_FINISH: if (ctl.run_control) state <= PSPWM_RUN; else if (cycle_end) state <= PSPWM_IDLE;
                default: state <= PSPWM_IDLE;
            endcase
        end
    end

    pspwm_ramp_type ramp;
    assign ramp = pspwm_ramp_type'(cfg.ramp_mode_select);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            counter <= 12'h000;
            enh_cycle <= 4'h0;
        end else if (!running) begin
            counter <= 12'h000;
            enh_cycle <= 4'h0;
        end else if (cycle_end) begin
            counter <= 12'h000;
            enh_cycle <= enh_cycle + 4'h1;
        end else if (tick) begin
            counter <= counter + 12'h001;
        end
    end

    // Shadow to live update under lock and autolock
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rb_written_last <= 1'b0;
            pending <= 1'b0;
        end else begin
            if (lo_commit || (wr_en && paddr == `PSPWM_OFF_SYNC_OUT)) begin
                rb_written_last <= paddr == `PSPWM_OFF_RESET_B;
                pending <= 1'b1;
            end else if (live == staged) begin
                pending <= 1'b0;
            end
        end
    end
    logic apply;
    assign apply = cfg.auto_update_hold ? (cycle_end && rb_written_last) : !cfg.update_hold;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            live <= '0;
        end else if (apply) begin
            live <= staged;
        end
    end

    // Comparators and waveforms
    logic [3:0] match;
    logic [11:0] cmp_val [4];
    assign cmp_val[0] = live.set_a;
    assign cmp_val[1] = live.reset_a;
    assign cmp_val[2] = live.set_b;
    assign cmp_val[3] = live.reset_b[11:0];
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_cmp
            assign match[gi] = tick && running && counter == cmp_val[gi] + {11'h000, fm_add && fm_tgt[gi]};
        end
    endgenerate

    logic [1:0] sel_a, sel_b;
    logic fault_a, fault_b;
    assign sel_a = {staged.sync_out.input_select_a_hi, input_lo_sel[0]};
    assign sel_b = {staged.sync_out.input_select_b_hi, input_lo_sel[1]};
    function automatic logic pick(input logic [1:0] s, input logic m, input logic c,
                                  input logic a, input logic b);
        case (s)
            2'h0: pick = m;
            2'h1: pick = c;
            2'h2: pick = a;
            default: pick = b;
        endcase
    endfunction
    assign fault_a = pick(sel_a, stage_input_main, comparator_out, stage_input_alt_a, stage_input_alt_b);
    assign fault_b = pick(sel_b, stage_input_main, comparator_out, stage_input_alt_a, stage_input_alt_b);

    logic wave_a, wave_b;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wave_a <= 1'b0;
            wave_b <= 1'b0;
        end else begin
            if (match[1] || fault_a || !running) wave_a <= 1'b0;
            else if (match[0]) wave_a <= 1'b1;
            if (match[3] || fault_b || !running) wave_b <= 1'b0;
            else if (match[2]) wave_b <= 1'b1;
        end
    end

    // Pins: direct fault gating applied asynchronously after the flops
    logic act_a, act_b;
    assign act_a = wave_a && !(ctl.direct_fault_out_a && fault_a);
    assign act_b = wave_b && !(ctl.direct_fault_out_b && fault_b);
    assign pins.out_a = live.sync_out.out_a_pin_enable ? (act_a ~^ cfg.output_polarity) : port_out_a;
    assign pins.out_b = live.sync_out.out_b_pin_enable ? (act_b ~^ cfg.output_polarity) : port_out_b;
    assign pins.out_a_oe = 1'b1;
    assign pins.out_b_oe = 1'b1;

    logic sync_evt;
    always_comb begin
        case (live.sync_out.adc_sync_select)
            2'h0: sync_evt = match[0];
            2'h1: sync_evt = match[1] || (fault_a && wave_a);
            2'h2: sync_evt = match[2];
            default: sync_evt = match[3] || (fault_b && wave_b);
        endcase
    end
    logic adc_sync_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) adc_sync_q <= 1'b0;
        else adc_sync_q <= sync_evt;
    end
    assign pins.adc_sync = adc_sync_q;

    // Event flags, set wins over write-one-to-clear
    logic [2:0] evt;
    logic fa_q, fb_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) {fa_q, fb_q} <= 2'h0;
        else {fa_q, fb_q} <= {fault_a, fault_b};
    end
    assign evt[`PSPWM_IRQ_EC] = cycle_end;
    assign evt[`PSPWM_IRQ_EEC] = cycle_end && enh_cycle == `PSPWM_ENH_LAST;
    assign evt[`PSPWM_IRQ_CAPT] = (fault_a && !fa_q) || (fault_b && !fb_q) || sync_error;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_flag <= 3'h0;
        end else begin
            irq_flag <= (irq_flag & ~((wr_en && paddr == `PSPWM_OFF_IRQ_FLAG) ? pwdata[2:0] : 3'h0)) | evt;
        end
    end
    assign irq = |(irq_flag & irq_mask);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                `PSPWM_OFF_SYNC_OUT: prdata <= {24'h0, staged.sync_out};
                `PSPWM_OFF_GEN_CFG: prdata <= {24'h0, cfg};
                `PSPWM_OFF_GEN_CTL: prdata <= {24'h0, ctl};
                `PSPWM_OFF_INPUT_CTL: prdata <= {30'h0, input_lo_sel};
                `PSPWM_OFF_IRQ_MASK: prdata <= {29'h0, irq_mask};
                `PSPWM_OFF_IRQ_FLAG: prdata <= {29'h0, irq_flag};
                `PSPWM_OFF_STATUS: prdata <= {14'h0, pending, running, 4'h0, counter};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    // Assertions
    ec_flag_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        cycle_end |=> irq_flag[0]) else $error("end of cycle flag not set");
    eec_flag_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        (cycle_end && enh_cycle == 4'hf) |=> irq_flag[1]) else $error("enhanced flag not set");
    capt_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
        sync_error |=> irq_flag[2]) else $error("capture flag not set");
    lock_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        (cfg.update_hold && !cfg.auto_update_hold) |=> $stable(live)) else $error("lock leaked");
    autolock_a: assert property (@(posedge clk) disable iff (!rst_n)
        (cfg.auto_update_hold && !cycle_end) |=> $stable(live)) else $error("autolock leaked");
    half_duty_a: assert property (@(posedge clk) disable iff (!rst_n)
        (lo_commit && paddr == 12'h010 && cfg.half_duty_mode) |=> staged.reset_a == staged.reset_b[11:0])
        else $error("fifty copy missing");
    out_a_port_a: assert property (@(posedge clk) disable iff (!rst_n)
        !live.sync_out.out_a_pin_enable |-> pins.out_a == port_out_a) else $error("pin A not port");
    out_b_port_a: assert property (@(posedge clk) disable iff (!rst_n)
        !live.sync_out.out_b_pin_enable |-> pins.out_b == port_out_b) else $error("pin B not port");
    run_start_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state == PSPWM_IDLE && ctl.run_control) |=> running) else $error("run ignored");
    sync_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
        (live.sync_out.adc_sync_select == 2'h2 && match[2]) |=> pins.adc_sync) else $error("sync missing");
    cover_cycle_c: cover property (@(posedge clk) disable iff (!rst_n) cycle_end);
    cover_enh_c: cover property (@(posedge clk) disable iff (!rst_n) evt[1]);
    cover_finish_c: cover property (@(posedge clk) disable iff (!rst_n) state == PSPWM_FINISH ##1 !running);
endmodule // pspwm_top

// ### hdl/pspwm_map.svh
// Register offsets, field positions and reset values of the power stage PWM block
`ifndef PSPWM_MAP_SVH
`define PSPWM_MAP_SVH
`define PSPWM_OFF_SYNC_OUT 12'h000
`define PSPWM_OFF_SET_A 12'h004
`define PSPWM_OFF_RESET_A 12'h008
`define PSPWM_OFF_SET_B 12'h00c
`define PSPWM_OFF_RESET_B 12'h010
`define PSPWM_OFF_GEN_CFG 12'h014
`define PSPWM_OFF_GEN_CTL 12'h018
`define PSPWM_OFF_INPUT_CTL 12'h01c
`define PSPWM_OFF_IRQ_MASK 12'h020
`define PSPWM_OFF_IRQ_FLAG 12'h024
`define PSPWM_OFF_STATUS 12'h028
`define PSPWM_RST_BYTE 8'h00
`define PSPWM_RST_WORD 16'h0000
`define PSPWM_IRQ_EC 0
`define PSPWM_IRQ_EEC 1
`define PSPWM_IRQ_CAPT 2
`define PSPWM_ENH_LAST 4'hf
`define PSPWM_DIV_4 8'h03
`define PSPWM_DIV_32 8'h1f
`define PSPWM_DIV_256 8'hff
`endif

// ### hdl/pspwm_pkg.sv
// Types of the power stage PWM block
package pspwm_pkg;
    typedef struct packed {
        logic input_select_a_hi;
        logic input_select_b_hi;
        logic [1:0] adc_sync_select;
        logic rsv3;
        logic out_b_pin_enable;
        logic rsv1;
        logic out_a_pin_enable;
    } pspwm_sync_out_type;
    typedef struct packed {
        logic half_duty_mode;
        logic auto_update_hold;
        logic update_hold;
        logic [1:0] ramp_mode_select;
        logic output_polarity;
        logic clock_source_select;
        logic rsv0;
    } pspwm_cfg_type;
    typedef struct packed {
        logic [1:0] prescale_select;
        logic flank_mod_select_hi;
        logic direct_fault_out_b;
        logic direct_fault_out_a;
        logic flank_mod_select_lo;
        logic complete_cycle_halt;
        logic run_control;
    } pspwm_ctl_type;
    typedef struct packed {
        logic [11:0] set_a;
        logic [11:0] reset_a;
        logic [11:0] set_b;
        logic [15:0] reset_b;
        pspwm_sync_out_type sync_out;
    } pspwm_shadow_type;
    typedef struct packed {
        logic out_a;
        logic out_a_oe;
        logic out_b;
        logic out_b_oe;
        logic adc_sync;
    } pspwm_pins_type;
    typedef enum logic [1:0] {PSPWM_RAMP1, PSPWM_RAMP2, PSPWM_RAMP4, PSPWM_RAMP_RSV} pspwm_ramp_type;
    typedef enum {PSPWM_IDLE, PSPWM_RUN, PSPWM_FINISH} pspwm_state_type;
endpackage

// ### sim/pspwm_stage_model.sv
// Far-side model: counter clock sources, fault inputs and ADC sampler
`timescale 1ns/100ps
module pspwm_stage_model (
    input wire logic clk,
    input wire logic reset_n,
    input wire pspwm_pkg::pspwm_pins_type pins,
    input wire logic [2:0] fault_cmd,
    output logic fast_clock,
    output logic slow_clock,
    output logic stage_input_main,
    output logic stage_input_alt_a,
    output logic stage_input_alt_b,
    output int adc_count
);
    import pspwm_pkg::*;
    logic slow_phase;
    // Fast source every cycle, slow source every second cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            slow_phase <= 1'b0;
        end else begin
            slow_phase <= ~slow_phase;
        end
    end
    assign fast_clock = 1'b1;
    assign slow_clock = slow_phase;
    assign {stage_input_alt_b, stage_input_alt_a, stage_input_main} = fault_cmd;
    // Sampler takes one conversion per sync pulse
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            adc_count <= 0;
        end else if (pins.adc_sync) begin
            adc_count <= adc_count + 1;
        end
    end
endmodule // pspwm_stage_model

// ### sim/power_stage_pwm_config_bench.sv
// Register-level bench of the power stage PWM block
`timescale 1ns/100ps
`include "pspwm_map.svh"
module power_stage_pwm_config_bench;
    import pspwm_pkg::*;
    logic clk, reset_n, psel, penable, pwrite, pready, pslverr, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic fast_clock, slow_clock, s_main, s_alt_a, s_alt_b, sync_error, port_out_a, port_out_b, pol0, rsp, autorun;
    logic [2:0] fault_cmd;
    pspwm_pins_type pins;
    int err_total, tests_run, cyc, adc_count, n, a0;
    pspwm_top dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .fast_clock(fast_clock), .slow_clock(slow_clock), .slave_autorun(autorun),
        .stage_input_main(s_main), .stage_input_alt_a(s_alt_a), .stage_input_alt_b(s_alt_b),
        .comparator_out(1'b0), .sync_error(sync_error), .port_out_a(port_out_a),
        .port_out_b(port_out_b), .pins(pins), .irq(irq));
    pspwm_stage_model stage (.clk(clk), .reset_n(reset_n), .pins(pins), .fault_cmd(fault_cmd),
        .fast_clock(fast_clock), .slow_clock(slow_clock), .stage_input_main(s_main),
        .stage_input_alt_a(s_alt_a), .stage_input_alt_b(s_alt_b), .adc_count(adc_count));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;
    task automatic close_out();
        $display("Checks %0d, errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Setup then access phase, held until pready at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        rsp = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Shared high-byte latch first, low byte commits both
    task automatic wr16(input logic [11:0] a, input logic [15:0] v);
        apb(1'b1, a, {15'h0000, 1'b1, v[15:8], 8'h00});
        apb(1'b1, a, {24'h000000, v[7:0]});
    endtask
    // Look one edge on, so a flag cleared at this edge is not taken as set
    task automatic wait_irq();
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (irq !== 1'b1 && n < 6000);
        chk("irq wait", 32'h1, {31'h0, irq});
    endtask
    // Cycles between two end-of-cycle events
    task automatic period(input int exp, input string what);
        apb(1'b1, `PSPWM_OFF_IRQ_FLAG, 32'h00000007);
        wait_irq();
        a0 = cyc;
        apb(1'b1, `PSPWM_OFF_IRQ_FLAG, 32'h00000007);
        wait_irq();
        chk(what, exp, cyc - a0);
    endtask
    initial begin
        {psel, penable, pwrite, sync_error, port_out_a, port_out_b, autorun} = 7'h00;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        fault_cmd = 3'h0;
        {err_total, tests_run, cyc} = 0;
        reset_n = 1'b0;
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk);
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, 12'(4 * i), 32'h00000000);
            chk("reset or write-only read", {24'h000000, `PSPWM_RST_BYTE}, rd);
        end
        port_out_a <= 1'b1;
        @(posedge clk);
        #1 chk("port pins", 32'h2, {pins.out_a, pins.out_b});
        chk("pin enables", 32'h3, {pins.out_a_oe, pins.out_b_oe});
        apb(1'b1, 12'h040, 32'h000000ff);
        chk("unmapped error", 32'h1, rsp);
        apb(1'b0, 12'h040, 32'h00000000);
        chk("unmapped read", 32'h0, rd);
        apb(1'b1, `PSPWM_OFF_SYNC_OUT, 32'h000000f5);
        apb(1'b0, `PSPWM_OFF_SYNC_OUT, 32'h00000000);
        chk("sync and output", 32'h000000f5, rd);
        #1 pol0 = pins.out_a;
        apb(1'b1, `PSPWM_OFF_GEN_CFG, 32'h00000006);
        apb(1'b0, `PSPWM_OFF_GEN_CFG, 32'h00000000);
        chk("configuration", 32'h00000006, rd);
        #1 chk("polarity", {31'h0, ~pol0}, pins.out_a);
        apb(1'b1, `PSPWM_OFF_GEN_CFG, 32'h00000002);
        wr16(`PSPWM_OFF_RESET_B, 16'h0007);
        apb(1'b1, `PSPWM_OFF_IRQ_MASK, 32'h00000001);
        for (int p = 0; p < 4; p++) begin
            apb(1'b1, `PSPWM_OFF_GEN_CTL, 32'(8'h01 | (p << 6)));
            period(8 * (p == 0 ? 1 : p == 1 ? 4 : p == 2 ? 32 : 256), "prescaled period");
        end
        apb(1'b1, `PSPWM_OFF_GEN_CTL, 32'h00000001);
        apb(1'b1, `PSPWM_OFF_GEN_CFG, 32'h00000000);
        period(16, "slow clock period");
        apb(1'b1, `PSPWM_OFF_GEN_CFG, 32'h00000022);
        wr16(`PSPWM_OFF_RESET_B, 16'h0003);
        period(8, "locked period");
        apb(1'b1, `PSPWM_OFF_GEN_CFG, 32'h00000002);
        period(4, "released period");
        apb(1'b1, `PSPWM_OFF_GEN_CFG, 32'h00000062);
        wr16(`PSPWM_OFF_RESET_B, 16'h0007);
        period(8, "autolock period");
        apb(1'b1, `PSPWM_OFF_GEN_CFG, 32'h00000082);
        wr16(`PSPWM_OFF_RESET_B, 16'h0007);
        for (int s = 0; s < 4; s++) begin
            apb(1'b1, `PSPWM_OFF_SYNC_OUT, 32'(8'h05 | (s << 4)));
            repeat (4) @(posedge clk);
            n = adc_count;
            repeat (64) @(posedge clk);
            chk("adc sync count", 32'd8, adc_count - n);
        end
        apb(1'b1, `PSPWM_OFF_IRQ_MASK, 32'h00000002);
        apb(1'b1, `PSPWM_OFF_IRQ_FLAG, 32'h00000007);
        wait_irq();
        apb(1'b0, `PSPWM_OFF_IRQ_FLAG, 32'h00000000);
        chk("enhanced cycle flag", 32'h2, rd & 32'h2);
        apb(1'b1, `PSPWM_OFF_IRQ_MASK, 32'h00000004);
        apb(1'b1, `PSPWM_OFF_IRQ_FLAG, 32'h00000007);
        sync_error <= 1'b1;
        @(posedge clk);
        sync_error <= 1'b0;
        repeat (2) @(posedge clk);
        chk("capture irq", 32'h1, irq);
        apb(1'b1, `PSPWM_OFF_IRQ_MASK, 32'h00000000);
        #1 chk("masked irq", 32'h0, irq);
        apb(1'b1, `PSPWM_OFF_IRQ_FLAG, 32'h00000004);
        apb(1'b0, `PSPWM_OFF_IRQ_FLAG, 32'h00000000);
        chk("cleared capture flag", 32'h0, rd & 32'h4);
        apb(1'b1, `PSPWM_OFF_GEN_CTL, 32'h00000003);
        apb(1'b1, `PSPWM_OFF_GEN_CTL, 32'h00000002);
        apb(1'b0, `PSPWM_OFF_STATUS, 32'h00000000);
        chk("finishing cycle", 32'h1, rd[16]);
        repeat (10) @(posedge clk);
        apb(1'b0, `PSPWM_OFF_STATUS, 32'h00000000);
        chk("halted", 32'h0, rd[16]);
        autorun <= 1'b1;
        apb(1'b0, `PSPWM_OFF_STATUS, 32'h00000000);
        chk("slave run", 32'h1, rd[16]);
        autorun <= 1'b0;
        repeat (10) @(posedge clk);
        apb(1'b0, `PSPWM_OFF_STATUS, 32'h00000000);
        chk("slave halted", 32'h0, rd[16]);
        close_out();
    end
    initial begin
        repeat (60000) @(posedge clk);
        err_total++;
        close_out();
    end
endmodule // power_stage_pwm_config_bench
